// ===== hdl/remote_map_pkg.sv
// constants for the remote target map and link status bank
package remote_map_pkg;
	localparam int ADDR_W = 8; // register address width
	localparam int DATA_W = 8; // register data width
	localparam int TGT_W = 7; // i2c target address width
	localparam int CNT_W = 16; // back-channel error count width
	// register offsets
	localparam logic [ADDR_W-1:0] OFS_RX_ADDR = 8'h06;
	localparam logic [ADDR_W-1:0] OFS_PHYS_ADDR = 8'h07;
	localparam logic [ADDR_W-1:0] OFS_ALIAS_ADDR = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_ERRCNT_LO = 8'h0a;
	localparam logic [ADDR_W-1:0] OFS_ERRCNT_HI = 8'h0b;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0c;
	// field positions
	localparam int ADDR_FIELD_LSB = 1; // address fields sit in bits 7:1
	localparam int LOCK_BIT = 0; // receiver address lock in bit 0
	localparam int ST_SELFTEST_ERR = 3; // self-test check error
	localparam int ST_PCLK_OK = 2; // pixel clock valid
	localparam int ST_LINK_ERR = 1; // link error during normal traffic
	localparam int ST_LINK_OK = 0; // cable link detected
	// reset values
	localparam logic [TGT_W-1:0] RST_TGT = 7'h00;
	localparam logic [CNT_W-1:0] RST_CNT = 16'h0000;
	localparam logic [DATA_W-1:0] RST_DATA = 8'h00;
	localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	localparam logic [TGT_W-1:0] TGT_NONE = 7'h00; // zero disables
endpackage : remote_map_pkg

// ===== hdl/remote_map_if.sv
// carrier between the register bank and the address mapper
`timescale 1ns/1ps
`default_nettype none
interface remote_map_if;
	import remote_map_pkg::*;
	logic [TGT_W-1:0] rxAddr; // remote receiver address
	logic [TGT_W-1:0] physAddr; // physical remote target address
	logic [TGT_W-1:0] aliasAddr; // alias of the remote target
	modport bank (output rxAddr, output physAddr, output aliasAddr);
	modport mapper (input rxAddr, input physAddr, input aliasAddr);
endinterface : remote_map_if
`default_nettype wire

// ===== hdl/remote_addr_mapper.sv
// maps a local i2c target address to the address forwarded across the link
`timescale 1ns/1ps
`default_nettype none
module remote_addr_mapper
	import remote_map_pkg::*;
(
	input wire logic clk_sys, // system clock
	input wire logic rst_b, // async reset, active low
	remote_map_if.mapper map, // programmed addresses
	input wire logic reqValid, // one-cycle address request
	input wire logic [TGT_W-1:0] reqAddr, // local i2c target address
	output logic fwdValid, // forward pulse
	output logic [TGT_W-1:0] fwdAddr, // address sent across the link
	output logic fwdToReceiver, // forward goes to the receiver chip
	output logic fwdRefused // request not forwarded
);
	typedef struct packed
	{
		logic valid; // forward pulse
		logic [TGT_W-1:0] addr; // forwarded address
		logic toRx; // target is receiver itself
		logic refused; // refusal pulse
	} map_s;
	map_s cur;
	map_s next_cur;
	logic aliasHit; // matches enabled alias
	logic rxHit; // matches enabled receiver address

	// a zero field never matches, so it disables its target
	assign aliasHit = (map.aliasAddr != TGT_NONE)
		&& (reqAddr == map.aliasAddr);
	assign rxHit = (map.rxAddr != TGT_NONE)
		&& (reqAddr == map.rxAddr);

	// decide one answer per request; alias checked first
	always_comb
	begin
		next_cur = cur;
		next_cur.valid = 1'b0;
		next_cur.refused = 1'b0;
		if (reqValid)
		begin
			if (aliasHit)
			begin
				next_cur.valid = 1'b1;
				next_cur.addr = map.physAddr;
				next_cur.toRx = 1'b0;
			end
			else if (rxHit)
			begin
				next_cur.valid = 1'b1;
				next_cur.addr = map.rxAddr;
				next_cur.toRx = 1'b1;
			end
			else
			begin
				next_cur.refused = 1'b1; // no enabled remote match
			end
		end
	end

	// register the answer so the outputs come from flip-flops
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			cur <= '0;
		else
			cur <= next_cur;
	end

	assign fwdValid = cur.valid;
	assign fwdAddr = cur.addr;
	assign fwdToReceiver = cur.toRx;
	assign fwdRefused = cur.refused;
endmodule : remote_addr_mapper
`default_nettype wire

// ===== hdl/remote_map_status_bank.sv
// register bank for remote target mapping and back-channel link status
`timescale 1ns/1ps
`default_nettype none
module remote_map_status_bank
	import remote_map_pkg::*;
(
	input wire logic clk_sys, // system clock, 25 MHz
	input wire logic rst_b, // async reset, active low
	input wire logic regWrite, // one-cycle write strobe
	input wire logic regRead, // one-cycle read strobe
	input wire logic [ADDR_W-1:0] regAddr, // register offset
	input wire logic [DATA_W-1:0] regWdata, // write data
	output logic [DATA_W-1:0] regRdata, // read data, held
	input wire logic rxLock, // receive lock level
	input wire logic learnValid, // learned receiver address pulse
	input wire logic [TGT_W-1:0] learnAddr, // address learned on the link
	input wire logic linkDetect, // cable link present level
	input wire logic pclkValid, // valid pixel clock level
	input wire logic crcError, // back-channel crc error pulse
	input wire logic selftestActive, // self-test running level
	input wire logic selftestStart, // self-test restart pulse
	input wire logic errorClear, // error clear command pulse
	input wire logic reqValid, // local i2c request pulse
	input wire logic [TGT_W-1:0] reqAddr, // local i2c target address
	output logic fwdValid, // forward pulse
	output logic [TGT_W-1:0] fwdAddr, // forwarded address
	output logic fwdToReceiver, // forward goes to receiver chip
	output logic fwdRefused, // request not forwarded
	output logic [TGT_W-1:0] remoteReceiverAddress, // current receiver id
	output logic receiverAddressLock // current lock bit
);
	typedef struct packed
	{
		logic [TGT_W-1:0] rxAddr; // remote receiver address
		logic lock; // receiver address lock
		logic [TGT_W-1:0] physAddr; // physical target address
		logic [TGT_W-1:0] aliasAddr; // target alias
		logic [CNT_W-1:0] errCount; // back-channel error count
		logic selftestErr; // self-test check error flag
		logic linkErr; // normal traffic error flag
		logic [DATA_W-1:0] rdata; // held read data
	} bank_s;
	bank_s cur;
	bank_s next_cur;
	logic wrRx; // write to receiver address register
	logic wrPhys; // write to physical address register
	logic wrAlias; // write to alias register
	logic [DATA_W-1:0] statusByte; // assembled status register

	remote_map_if mapBus (); // carrier to the mapper

	assign wrRx = regWrite && (regAddr == OFS_RX_ADDR);
	assign wrPhys = regWrite && (regAddr == OFS_PHYS_ADDR);
	assign wrAlias = regWrite && (regAddr == OFS_ALIAS_ADDR);

	// live bits read the inputs directly; sticky bits come from flops
	always_comb
	begin
		statusByte = RST_DATA;
		statusByte[ST_SELFTEST_ERR] = cur.selftestErr;
		statusByte[ST_PCLK_OK] = pclkValid;
		statusByte[ST_LINK_ERR] = cur.linkErr;
		statusByte[ST_LINK_OK] = linkDetect;
	end

	// next-state logic for the whole bank
	always_comb
	begin
		next_cur = cur;
		// receiver address: software write wins over an autoload
		if (wrRx)
		begin
			next_cur.rxAddr = regWdata[DATA_W-1:ADDR_FIELD_LSB];
			next_cur.lock = regWdata[LOCK_BIT];
		end
		else if (rxLock && learnValid && !cur.lock)
		begin
			next_cur.rxAddr = learnAddr;
		end
		if (wrPhys)
			next_cur.physAddr = regWdata[DATA_W-1:ADDR_FIELD_LSB];
		if (wrAlias)
			next_cur.aliasAddr = regWdata[DATA_W-1:ADDR_FIELD_LSB];
		// error count: increment after clear, so a same-cycle error counts
		if (errorClear)
			next_cur.errCount = RST_CNT;
		if (crcError && (next_cur.errCount != CNT_MAX))
			next_cur.errCount = next_cur.errCount + CNT_ONE;
		// self-test flag: clears first, a same-cycle error still sets
		if (errorClear || selftestStart)
			next_cur.selftestErr = 1'b0;
		if (crcError && selftestActive)
			next_cur.selftestErr = 1'b1;
		// normal-traffic flag: only link loss or error clear resets it
		if (errorClear)
			next_cur.linkErr = 1'b0;
		if (crcError && !selftestActive)
			next_cur.linkErr = 1'b1;
		// link loss overrides; no traffic can be valid without a link
		if (!linkDetect)
		begin
			next_cur.selftestErr = 1'b0;
			next_cur.linkErr = 1'b0;
		end
		// read data is captured on the strobe and held until the next
		if (regRead)
		begin
			case (regAddr)
				OFS_RX_ADDR:
					next_cur.rdata = {cur.rxAddr, cur.lock};
				OFS_PHYS_ADDR:
					next_cur.rdata = {cur.physAddr, 1'b0};
				OFS_ALIAS_ADDR:
					next_cur.rdata = {cur.aliasAddr, 1'b0};
				OFS_ERRCNT_LO:
					next_cur.rdata = cur.errCount[DATA_W-1:0];
				OFS_ERRCNT_HI:
					next_cur.rdata = cur.errCount[CNT_W-1:DATA_W];
				OFS_STATUS:
					next_cur.rdata = statusByte;
				default:
					next_cur.rdata = RST_DATA; // unmapped reads zero
			endcase
		end
	end

	// one register stage for all state
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			cur <= '0;
		else
			cur <= next_cur;
	end

	// hand the programmed addresses to the mapper
	assign mapBus.rxAddr = cur.rxAddr;
	assign mapBus.physAddr = cur.physAddr;
	assign mapBus.aliasAddr = cur.aliasAddr;

	remote_addr_mapper u_mapper (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.map(mapBus.mapper),
		.reqValid(reqValid),
		.reqAddr(reqAddr),
		.fwdValid(fwdValid),
		.fwdAddr(fwdAddr),
		.fwdToReceiver(fwdToReceiver),
		.fwdRefused(fwdRefused)
	);

	assign regRdata = cur.rdata;
	assign remoteReceiverAddress = cur.rxAddr;
	assign receiverAddressLock = cur.lock;
endmodule : remote_map_status_bank
`default_nettype wire

// ===== bench/remote_map_status_bank_sva.sv
// port assertions for the remote map and status bank
`timescale 1ns/1ps
`default_nettype none
module remote_map_status_bank_sva
	import remote_map_pkg::*;
(
	input wire logic clk_sys, // clock
	input wire logic rst_b, // reset
	input wire logic regWrite, // write strobe
	input wire logic regRead, // read strobe
	input wire logic [ADDR_W-1:0] regAddr, // offset
	input wire logic [DATA_W-1:0] regWdata, // write data
	input wire logic [DATA_W-1:0] regRdata, // read data
	input wire logic rxLock, // receive lock
	input wire logic learnValid, // learned pulse
	input wire logic [TGT_W-1:0] learnAddr, // learned id
	input wire logic linkDetect, // link level
	input wire logic pclkValid, // pixel clock level
	input wire logic reqValid, // request pulse
	input wire logic [TGT_W-1:0] reqAddr, // requested id
	input wire logic fwdValid, // forward pulse
	input wire logic [TGT_W-1:0] fwdAddr, // forwarded id
	input wire logic fwdToReceiver, // forward to receiver
	input wire logic fwdRefused, // refused pulse
	input wire logic [TGT_W-1:0] remoteReceiverAddress, // receiver id
	input wire logic receiverAddressLock // lock bit
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	logic idWr; // software write to the receiver id register
	assign idWr = regWrite && regAddr == OFS_RX_ADDR;
	a_id_write: assert property (idWr |=>
		remoteReceiverAddress == $past(regWdata[7:1])
		&& receiverAddressLock == $past(regWdata[0])) else $error("id write");
	a_lock_holds: assert property (receiverAddressLock && !idWr
		|=> $stable(remoteReceiverAddress)) else $error("lock broken");
	a_autoload_id: assert property (rxLock && learnValid
		&& !receiverAddressLock && !idWr
		|=> remoteReceiverAddress == $past(learnAddr)) else $error("no load");
	a_no_stray_load: assert property (!(rxLock && learnValid) && !idWr
		|=> $stable(remoteReceiverAddress)) else $error("stray load");
	a_status_live: assert property (regRead && regAddr == OFS_STATUS
		|=> regRdata[2] == $past(pclkValid) && regRdata[0] == $past(linkDetect)
		&& regRdata[7:4] == 4'h0) else $error("status bits");
	a_rdata_held: assert property (!regRead |=> $stable(regRdata))
		else $error("read data moved");
	a_one_answer: assert property (reqValid |=> fwdValid != fwdRefused)
		else $error("answer count");
	a_zero_refused: assert property (reqValid && reqAddr == TGT_NONE
		|=> fwdRefused) else $error("zero forwarded");
	a_rx_forward: assert property (fwdValid && fwdToReceiver
		|-> fwdAddr == $past(remoteReceiverAddress)) else $error("rx id");
endmodule : remote_map_status_bank_sva
bind remote_map_status_bank remote_map_status_bank_sva i_sva (.clk_sys,
	.rst_b, .regWrite, .regRead, .regAddr, .regWdata, .regRdata, .rxLock,
	.learnValid, .learnAddr, .linkDetect, .pclkValid, .reqValid, .reqAddr,
	.fwdValid, .fwdAddr, .fwdToReceiver, .fwdRefused, .remoteReceiverAddress,
	.receiverAddressLock);
`default_nettype wire

// ===== bench/remote_rx_model.sv
// behavioural remote receiver: gains lock and reports its learned id
`timescale 1ns/1ps
`default_nettype none
module remote_rx_model
	import remote_map_pkg::*;
(
	input wire logic clk_sys, // system clock
	input wire logic doLearn, // bench asks for lock and id report
	input wire logic [TGT_W-1:0] learnId, // id this receiver answers to
	output logic rxLock, // receive lock level
	output logic learnValid, // learned id pulse
	output logic [TGT_W-1:0] learnAddr // learned id, junk when idle
);
	initial rxLock = 1'b0;
	initial learnValid = 1'b0;
	initial learnAddr = 7'h2a;
	// idle id lines toggle so a stale value can never look valid
	always @(posedge clk_sys)
	begin
		learnValid <= doLearn;
		learnAddr <= doLearn ? learnId : ~learnAddr;
		if (doLearn)
			rxLock <= 1'b1; // lock is kept once gained
	end
endmodule : remote_rx_model
`default_nettype wire

// ===== bench/tb_remote_map_status_bank.sv
// self-checking bench for the remote map and status bank
`timescale 1ns/1ps
`default_nettype none
module tb_remote_map_status_bank;
	import remote_map_pkg::*;
	logic clk_sys = 1'b0, rst_b = 1'b0; // clock and reset
	logic regWrite = 1'b0, regRead = 1'b0; // register strobes
	logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata; // register bus
	logic linkDetect = 1'b0, pclkValid = 1'b0, crcError = 1'b0; // link state
	logic selftestActive = 1'b0, selftestStart = 1'b0, errorClear = 1'b0;
	logic reqValid = 1'b0, doLearn = 1'b0, rxLock, learnValid; // requests
	logic [6:0] reqAddr = 7'h00, learnId = 7'h00, learnAddr; // ids
	logic fwdValid, fwdToReceiver, fwdRefused, receiverAddressLock;
	logic [6:0] fwdAddr, remoteReceiverAddress; // mapper results
	int miscompares = 0, nTests = 0; // tallies
	always #20 clk_sys = ~clk_sys; // 25 MHz
	remote_rx_model i_rx (.clk_sys, .doLearn, .learnId, .rxLock, .learnValid,
		.learnAddr);
	remote_map_status_bank i_dut (.clk_sys, .rst_b, .regWrite, .regRead,
		.regAddr, .regWdata, .regRdata, .rxLock, .learnValid, .learnAddr,
		.linkDetect, .pclkValid, .crcError, .selftestActive, .selftestStart,
		.errorClear, .reqValid, .reqAddr, .fwdValid, .fwdAddr, .fwdToReceiver,
		.fwdRefused, .remoteReceiverAddress, .receiverAddressLock);
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		nTests++;
		if (g !== e)
		begin
			miscompares++;
			$display("Error t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// read data appears just after the taking edge and is checked at the next negedge
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRead <= 1'b0;
		@(negedge clk_sys);
		chk(regRdata, e);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		regWrite <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk_sys);
		regWrite <= 1'b0;
	endtask : wr
	// e holds valid, refused, to-receiver and the forwarded id
	task automatic req(input logic [6:0] a, input logic [9:0] e);
		@(posedge clk_sys);
		reqValid <= 1'b1;
		reqAddr <= a;
		@(posedge clk_sys);
		reqValid <= 1'b0;
		@(negedge clk_sys);
		chk({fwdValid, fwdRefused}, e[9:8]);
		if (e[9])
			chk({fwdToReceiver, fwdAddr}, e[7:0]);
	endtask : req
	task automatic crc(input int n); // n errors on back-to-back cycles
		repeat (n) @(posedge clk_sys) crcError <= 1'b1;
		@(posedge clk_sys) crcError <= 1'b0;
	endtask : crc
	task automatic learn(input logic [6:0] a);
		@(posedge clk_sys) doLearn <= 1'b1;
		learnId <= a;
		@(posedge clk_sys) doLearn <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask : learn
	// offsets read after reset; 0x09 is a hole and must read zero too
	logic [7:0] offsets [7] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b,
		8'h0c};
	task automatic testReset; // every register, and a hole, reads zero
		foreach (offsets[i]) rd(offsets[i], 8'h00);
		$display("testReset done");
	endtask : testReset
	task automatic testMap;
		wr(OFS_PHYS_ADDR, 8'h2b);
		rd(OFS_PHYS_ADDR, 8'h2a);
		wr(OFS_ALIAS_ADDR, 8'h41);
		rd(OFS_ALIAS_ADDR, 8'h40);
		req(7'h20, 10'h215);
		req(7'h21, 10'h100);
		req(7'h00, 10'h100);
		wr(OFS_ALIAS_ADDR, 8'h00);
		req(7'h20, 10'h100);
		$display("testMap done");
	endtask : testMap
	task automatic testLearn;
		learn(7'h3c);
		rd(OFS_RX_ADDR, 8'h78);
		req(7'h3c, 10'h2bc);
		wr(OFS_RX_ADDR, 8'h00);
		req(7'h3c, 10'h100);
		wr(OFS_RX_ADDR, 8'h55);
		learn(7'h11);
		rd(OFS_RX_ADDR, 8'h55);
		chk({receiverAddressLock, remoteReceiverAddress}, 16'h00aa);
		req(7'h2a, 10'h2aa);
		$display("testLearn done");
	endtask : testLearn
	task automatic testErrors;
		@(posedge clk_sys) linkDetect <= 1'b1;
		pclkValid <= 1'b1;
		rd(OFS_STATUS, 8'h05);
		crc(3);
		wr(OFS_ERRCNT_LO, 8'hff);
		rd(OFS_ERRCNT_LO, 8'h03);
		rd(OFS_ERRCNT_HI, 8'h00);
		rd(OFS_STATUS, 8'h07);
		@(posedge clk_sys) selftestActive <= 1'b1;
		crc(1);
		selftestActive <= 1'b0;
		rd(OFS_STATUS, 8'h0f);
		@(posedge clk_sys) selftestStart <= 1'b1;
		@(posedge clk_sys) selftestStart <= 1'b0;
		rd(OFS_STATUS, 8'h07);
		@(posedge clk_sys) errorClear <= 1'b1;
		@(posedge clk_sys) errorClear <= 1'b0;
		rd(OFS_STATUS, 8'h05);
		rd(OFS_ERRCNT_LO, 8'h00);
		crc(1);
		rd(OFS_STATUS, 8'h07);
		@(posedge clk_sys) linkDetect <= 1'b0;
		pclkValid <= 1'b0;
		rd(OFS_STATUS, 8'h00);
		$display("testErrors done");
	endtask : testErrors
	task automatic stopTest;
		$display("compares %0d mismatches %0d", nTests, miscompares);
		if (miscompares == 0 && nTests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stopTest
	initial
	begin
		repeat (20) @(posedge clk_sys);
		rst_b <= 1'b1;
		testReset;
		testMap;
		testLearn;
		testErrors;
		stopTest;
	end
	// the tests need about 110 cycles; this leaves ample margin
	initial
	begin
		repeat (3000) @(posedge clk_sys);
		miscompares++;
		stopTest;
	end
endmodule : tb_remote_map_status_bank
`default_nettype wire
